// ---- rtl/ecsu_defs.svh ----
`ifndef ECSU_DEFS_SVH
`define ECSU_DEFS_SVH
// Status codes.
`define ECSU_ST_OK 8'h00
`define ECSU_ST_ALIGN 8'h01
`define ECSU_ST_OFFSET 8'h02
`define ECSU_ST_TABLE 8'h03
`define ECSU_ST_WDOG 8'h07
`define ECSU_ST_PARITY 8'h09
`define ECSU_ST_CSUM 8'h0a
`define ECSU_ST_CMD 8'h0b
`define ECSU_ST_LEN 8'h0c
`define ECSU_ST_ARG 8'h0d
`define ECSU_ST_WPROT 8'h0e
`define ECSU_ST_CODE 8'h0f
`define ECSU_ST_FIXED 8'h10
`define ECSU_ST_ADDR 8'h11
`define ECSU_ST_NOFIELD 8'h12
`define ECSU_ST_SIGMON 8'h1c
`define ECSU_ST_CURRENT 8'h1d
`define ECSU_ST_TEMP 8'h1e
`define ECSU_ST_SPEED 8'h1f
`define ECSU_ST_STUNREL 8'h20
// Command bytes.
`define ECSU_C_RDPOS 8'h42
`define ECSU_C_SETPOS 8'h43
`define ECSU_C_RDDATA 8'h4a
`define ECSU_C_STDATA 8'h4b
`define ECSU_C_FSTAT 8'h4c
`define ECSU_C_CREATE 8'h4d
`define ECSU_C_FREE 8'h4e
`define ECSU_C_CHCODE 8'h4f
`define ECSU_C_STATUS 8'h50
`define ECSU_C_TYPE 8'h52
`define ECSU_C_RESET 8'h53
`define ECSU_C_ADDR 8'h55
`define ECSU_C_SERIAL 8'h56
`define ECSU_C_CFG 8'h57
// Guard byte, code selector and field flag positions.
`define ECSU_GUARD_INIT 8'h55
`define ECSU_GUARD_SEL 8'hff
`define ECSU_FLD_WP_BIT 6
`define ECSU_FLD_FIX_BIT 7
`define ECSU_LEN_BAD 4'hf
`define ECSU_RXMAX 8
`endif

// ---- rtl/ecsu_pkg.sv ----
package ecsu_pkg;
   typedef enum logic [1:0] {ECSU_S_RX, ECSU_S_EXEC, ECSU_S_TX} ecsu_state_t;
endpackage

// ---- rtl/ecsu_top.sv ----
`timescale 1ns/10ps
`include "ecsu_defs.svh"
// Operation
// R01: With no fault present, a status query answers 00h.
// R02: Initialization faults report 01h alignment, 02h offset, 03h partition table.
// R03: A watchdog restart latches status 07h.
// R04: Frame faults report 09h parity, 0Ah checksum, 0Bh unknown command.
// R05: A wrong argument byte count is refused with 0Ch.
// R06: An argument outside permitted values is refused with 0Dh.
// R07: Writing a protected field gives 0Eh; a wrong access code gives 0Fh.
// R08: Resizing a fixed-size field is refused with 10h.
// R09: A word address beyond the field end is refused with 11h.
// R10: Accessing a field never created is refused with 12h.
// R11: Speed too high reports 1Fh; unreliable single-turn position reports 20h.
// R12: Monitoring faults report 1Ch signals, 1Dh current or RAM, 1Eh temperature.
// R13: Vital commands run only when their guard byte matches the stored one.
// R14: Set position, allocate address and configure interface need the guard.
// R15: The stored guard byte starts as 55h.
// R16: Decode 4Ah read data, 4Bh store data, 4Ch field status.
// R17: Decode 4Dh create field, 4Eh free memory, 4Fh change code.
// R18: Command 56h returns serial number and firmware version.
// R19: The multiturn count spans 4096 revolutions before wrapping.
// R20: Position is plain binary, rising for clockwise rotation.
// R21: Read position returns 27 bits of single-turn and multiturn data.
// R22: A refused command changes nothing and latches its status code.
module ecsu_top #(
   parameter int NFIELD = 4,
   parameter int MEM_BYTES = 128,
   parameter logic [7:0] TYPE_ID = 8'h5a, // Arbitrary value.
   parameter logic [31:0] SERIAL_NO = 32'h0000_1234, // Arbitrary value.
   parameter logic [7:0] FW_VERSION = 8'h01, // Arbitrary value.
   parameter logic [7:0] ADDR_INIT = 8'h00,
   parameter logic [7:0] MODE_INIT = 8'h00
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   input wire logic i_rx_last,
   input wire logic i_rx_par_err,
   output logic o_rx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_byte,
   output logic o_tx_last,
   output logic o_tx_err,
   input wire logic i_tx_ready,
   input wire logic [14:0] i_st_pos,
   input wire logic [11:0] i_mt_count,
   input wire logic i_align_bad,
   input wire logic i_offset_bad,
   input wire logic i_table_bad,
   input wire logic i_wdt_restart,
   input wire logic i_speed_high,
   input wire logic i_st_unreliable,
   input wire logic i_sig_mon,
   input wire logic i_tx_current,
   input wire logic i_ram_err,
   input wire logic i_temp_crit,
   output logic [7:0] o_bus_addr,
   output logic [7:0] o_line_mode
);
   localparam int FSZ = MEM_BYTES / NFIELD;
   localparam int MAW = $clog2(MEM_BYTES);

   function automatic logic [3:0] arg_len(input logic [7:0] c);
      case (c)
         `ECSU_C_RDPOS, `ECSU_C_FREE, `ECSU_C_STATUS, `ECSU_C_TYPE: arg_len = 4'h0;
         `ECSU_C_RESET, `ECSU_C_SERIAL: arg_len = 4'h0;
         `ECSU_C_SETPOS: arg_len = 4'h5;
         `ECSU_C_RDDATA, `ECSU_C_ADDR, `ECSU_C_CFG: arg_len = 4'h2;
         `ECSU_C_STDATA: arg_len = 4'h4;
         `ECSU_C_FSTAT: arg_len = 4'h1;
         `ECSU_C_CREATE, `ECSU_C_CHCODE: arg_len = 4'h3;
         default: arg_len = `ECSU_LEN_BAD;
      endcase
   endfunction

   ecsu_pkg::ecsu_state_t state, next_state;
   logic [7:0] rxb [`ECSU_RXMAX];
   logic [7:0] next_rxb [`ECSU_RXMAX];
   logic [3:0] rx_cnt, next_rx_cnt;
   logic rx_par, next_rx_par, rx_ovf, next_rx_ovf;
   logic [7:0] rx_csum, next_rx_csum;
   logic [7:0] txb [6];
   logic [7:0] next_txb [6];
   logic [2:0] tx_left, next_tx_left;
   logic tx_err, next_tx_err;
   logic [7:0] latched, next_latched;
   logic [7:0] guard, next_guard;
   logic [26:0] offset, next_offset;
   logic [7:0] bus_addr, next_bus_addr, line_mode, next_line_mode;
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] next_mem [MEM_BYTES];
   logic [5:0] fsize [NFIELD];
   logic [5:0] next_fsize [NFIELD];
   logic [7:0] fcode [NFIELD];
   logic [7:0] next_fcode [NFIELD];
   logic [NFIELD-1:0] fused, next_fused, fwp, next_fwp, ffix, next_ffix;
   logic [7:0] live, pre_code;
   logic [26:0] pos;

   ////////////////////////////////////////////////////////////////////////////
   // Live fault priority and frame-level checks.
   // R19 R20 R21 position forming
   assign pos = {i_mt_count, i_st_pos} + offset;

   // R02 R11 R12 live fault codes
   always_comb begin
      if (i_align_bad) live = `ECSU_ST_ALIGN;
      else if (i_offset_bad) live = `ECSU_ST_OFFSET;
      else if (i_table_bad) live = `ECSU_ST_TABLE;
      else if (i_sig_mon) live = `ECSU_ST_SIGMON;
      else if (i_tx_current || i_ram_err) live = `ECSU_ST_CURRENT;
      else if (i_temp_crit) live = `ECSU_ST_TEMP;
      else if (i_speed_high) live = `ECSU_ST_SPEED;
      else if (i_st_unreliable) live = `ECSU_ST_STUNREL;
      else live = `ECSU_ST_OK;
   end

   // R04 R05 frame checks
   always_comb begin
      if (rx_par) pre_code = `ECSU_ST_PARITY;
      else if (rx_csum != 8'h00) pre_code = `ECSU_ST_CSUM;
      else if (arg_len(rxb[0]) == `ECSU_LEN_BAD) pre_code = `ECSU_ST_CMD;
      else if (rx_ovf || rx_cnt < 4'h2 || arg_len(rxb[0]) != rx_cnt - 4'h2)
         pre_code = `ECSU_ST_LEN;
      else pre_code = `ECSU_ST_OK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive, execute and answer.
   always_comb begin
      logic [7:0] code;
      logic [MAW-1:0] idx;
      logic [7:0] f;
      logic [7:0] used_sum;
      logic [27:0] tgt;
      code = `ECSU_ST_OK;
      f = rxb[1];
      idx = '0;
      used_sum = 8'h00;
      tgt = {rxb[2][3:0], rxb[3], rxb[4], rxb[5]};
      next_state = state;
      next_rxb = rxb;
      next_rx_cnt = rx_cnt;
      next_rx_par = rx_par;
      next_rx_ovf = rx_ovf;
      next_rx_csum = rx_csum;
      next_txb = txb;
      next_tx_left = tx_left;
      next_tx_err = tx_err;
      next_latched = latched;
      next_guard = guard;
      next_offset = offset;
      next_bus_addr = bus_addr;
      next_line_mode = line_mode;
      next_mem = mem;
      next_fsize = fsize;
      next_fcode = fcode;
      next_fused = fused;
      next_fwp = fwp;
      next_ffix = ffix;
      for (int i = 0; i < NFIELD; i++) begin
         used_sum = used_sum + (fused[i] ? {2'b00, fsize[i]} : 8'h00);
      end
      case (state)
         ecsu_pkg::ECSU_S_RX: begin
            if (i_rx_valid) begin
               if (rx_cnt < 4'(`ECSU_RXMAX)) next_rxb[rx_cnt[2:0]] = i_rx_byte;
               else next_rx_ovf = 1'b1;
               if (rx_cnt != 4'hf) next_rx_cnt = rx_cnt + 4'h1;
               next_rx_par = rx_par | i_rx_par_err;
               next_rx_csum = rx_csum ^ i_rx_byte;
               if (i_rx_last) next_state = ecsu_pkg::ECSU_S_EXEC;
            end
         end
         ecsu_pkg::ECSU_S_EXEC: begin
            code = pre_code;
            for (int i = 0; i < 6; i++) next_txb[i] = 8'h00;
            next_tx_left = 3'd1;
            if (code == `ECSU_ST_OK) begin
               case (rxb[0])
                  `ECSU_C_RDPOS: begin
                     next_txb[0] = {5'h00, pos[26:24]};
                     next_txb[1] = pos[23:16];
                     next_txb[2] = pos[15:8];
                     next_txb[3] = pos[7:0];
                     next_tx_left = 3'd4;
                  end
                  // R13 R14 R06 guarded set position
                  `ECSU_C_SETPOS: begin
                     if (rxb[1] != guard) code = `ECSU_ST_CODE;
                     else if (rxb[2][7:3] != 5'h00) code = `ECSU_ST_ARG;
                     else next_offset = tgt[26:0] - {i_mt_count, i_st_pos};
                  end
                  // R16 R09 R10 field data access
                  `ECSU_C_RDDATA, `ECSU_C_STDATA, `ECSU_C_FSTAT: begin
                     idx = MAW'(f[1:0] * FSZ) + MAW'(rxb[2][4:0]);
                     if (f >= 8'(NFIELD)) code = `ECSU_ST_ARG;
                     else if (!fused[f[1:0]]) code = `ECSU_ST_NOFIELD;
                     else if (rxb[0] == `ECSU_C_FSTAT) begin
                        next_txb[0] = {ffix[f[1:0]], fwp[f[1:0]], fsize[f[1:0]]};
                     end else if (rxb[2] >= {2'b00, fsize[f[1:0]]}) code = `ECSU_ST_ADDR;
                     else if (rxb[0] == `ECSU_C_RDDATA) next_txb[0] = mem[idx];
                     // R07 protection and code check
                     else if (fwp[f[1:0]]) code = `ECSU_ST_WPROT;
                     else if (rxb[3] != fcode[f[1:0]]) code = `ECSU_ST_CODE;
                     else next_mem[idx] = rxb[4];
                  end
                  // R17 R08 R06 create field
                  `ECSU_C_CREATE: begin
                     if (f >= 8'(NFIELD) || rxb[2][5:0] > 6'(FSZ)) code = `ECSU_ST_ARG;
                     else if (fused[f[1:0]] && ffix[f[1:0]]) code = `ECSU_ST_FIXED;
                     else if (fused[f[1:0]] && rxb[3] != fcode[f[1:0]]) code = `ECSU_ST_CODE;
                     else begin
                        next_fused[f[1:0]] = 1'b1;
                        next_fsize[f[1:0]] = rxb[2][5:0];
                        next_fwp[f[1:0]] = rxb[2][`ECSU_FLD_WP_BIT];
                        next_ffix[f[1:0]] = rxb[2][`ECSU_FLD_FIX_BIT];
                     end
                  end
                  // R17 free memory
                  `ECSU_C_FREE: next_txb[0] = 8'(MEM_BYTES) - used_sum;
                  // R17 R07 change access code
                  `ECSU_C_CHCODE: begin
                     if (f == `ECSU_GUARD_SEL) begin
                        if (rxb[2] != guard) code = `ECSU_ST_CODE;
                        else next_guard = rxb[3];
                     end else if (f >= 8'(NFIELD)) code = `ECSU_ST_ARG;
                     else if (!fused[f[1:0]]) code = `ECSU_ST_NOFIELD;
                     else if (rxb[2] != fcode[f[1:0]]) code = `ECSU_ST_CODE;
                     else next_fcode[f[1:0]] = rxb[3];
                  end
                  // R01 R02 status query
                  `ECSU_C_STATUS: begin
                     next_txb[0] = (latched != `ECSU_ST_OK) ? latched : live;
                     next_latched = `ECSU_ST_OK;
                  end
                  `ECSU_C_TYPE: next_txb[0] = TYPE_ID;
                  `ECSU_C_RESET: next_latched = `ECSU_ST_OK;
                  // R14 guarded address and interface setup
                  `ECSU_C_ADDR, `ECSU_C_CFG: begin
                     if (rxb[1] != guard) code = `ECSU_ST_CODE;
                     else if (rxb[0] == `ECSU_C_ADDR) next_bus_addr = rxb[2];
                     else next_line_mode = rxb[2];
                  end
                  // R18 serial number and version
                  `ECSU_C_SERIAL: begin
                     next_txb[0] = SERIAL_NO[31:24];
                     next_txb[1] = SERIAL_NO[23:16];
                     next_txb[2] = SERIAL_NO[15:8];
                     next_txb[3] = SERIAL_NO[7:0];
                     next_txb[4] = FW_VERSION;
                     next_tx_left = 3'd5;
                  end
                  default: code = `ECSU_ST_CMD;
               endcase
            end
            next_tx_err = (code != `ECSU_ST_OK);
            // R22 refusal keeps state and latches code
            if (code != `ECSU_ST_OK) begin
               next_txb[0] = code;
               next_tx_left = 3'd1;
               next_latched = code;
               next_offset = offset;
               next_guard = guard;
               next_bus_addr = bus_addr;
               next_line_mode = line_mode;
               next_mem = mem;
               next_fsize = fsize;
               next_fcode = fcode;
               next_fused = fused;
               next_fwp = fwp;
               next_ffix = ffix;
            end
            next_rx_cnt = 4'h0;
            next_rx_par = 1'b0;
            next_rx_ovf = 1'b0;
            next_rx_csum = 8'h00;
            next_state = ecsu_pkg::ECSU_S_TX;
         end
         ecsu_pkg::ECSU_S_TX: begin
            if (i_tx_ready) begin
               for (int i = 0; i < 5; i++) next_txb[i] = txb[i+1];
               next_txb[5] = 8'h00;
               next_tx_left = tx_left - 3'd1;
               if (tx_left == 3'd1) next_state = ecsu_pkg::ECSU_S_RX;
            end
         end
         default: next_state = ecsu_pkg::ECSU_S_RX;
      endcase
      // R03 watchdog event wins over any clear
      if (i_wdt_restart) next_latched = `ECSU_ST_WDOG;
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ecsu_pkg::ECSU_S_RX;
         rxb <= '{default: 8'h00};
         rx_cnt <= 4'h0;
         rx_par <= 1'b0;
         rx_ovf <= 1'b0;
         rx_csum <= 8'h00;
         txb <= '{default: 8'h00};
         tx_left <= 3'd0;
         tx_err <= 1'b0;
         latched <= `ECSU_ST_OK;
         // R15 delivered guard value
         guard <= `ECSU_GUARD_INIT;
         offset <= 27'h0;
         bus_addr <= ADDR_INIT;
         line_mode <= MODE_INIT;
         mem <= '{default: 8'h00};
         fsize <= '{default: 6'h00};
         fcode <= '{default: `ECSU_GUARD_INIT};
         fused <= '0;
         fwp <= '0;
         ffix <= '0;
      end else begin
         state <= next_state;
         rxb <= next_rxb;
         rx_cnt <= next_rx_cnt;
         rx_par <= next_rx_par;
         rx_ovf <= next_rx_ovf;
         rx_csum <= next_rx_csum;
         txb <= next_txb;
         tx_left <= next_tx_left;
         tx_err <= next_tx_err;
         latched <= next_latched;
         guard <= next_guard;
         offset <= next_offset;
         bus_addr <= next_bus_addr;
         line_mode <= next_line_mode;
         mem <= next_mem;
         fsize <= next_fsize;
         fcode <= next_fcode;
         fused <= next_fused;
         fwp <= next_fwp;
         ffix <= next_ffix;
      end
   end

   assign o_rx_ready = (state == ecsu_pkg::ECSU_S_RX);
   assign o_tx_valid = (state == ecsu_pkg::ECSU_S_TX);
   assign o_tx_byte = txb[0];
   assign o_tx_last = o_tx_valid && tx_left == 3'd1;
   assign o_tx_err = tx_err;
   assign o_bus_addr = bus_addr;
   assign o_line_mode = line_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Checks. The exec state is one cycle, so the answer byte shows at the next edge.
   logic ex;
   assign ex = (state == ecsu_pkg::ECSU_S_EXEC);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);

   property p_idle_ok;
      ex && pre_code == 8'h00 && rxb[0] == 8'h50 && latched == 8'h00 && live == 8'h00
         && !i_wdt_restart |=> o_tx_valid && o_tx_byte == 8'h00 && !o_tx_err;
   endproperty
   a_idle_ok: assert property (p_idle_ok) else $error("status not 00h"); // R01
   property p_wdog;
      i_wdt_restart |=> latched == 8'h07;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog code lost"); // R03
   property p_parity;
      ex && rx_par |=> o_tx_valid && o_tx_last && o_tx_err && o_tx_byte == 8'h09;
   endproperty
   a_parity: assert property (p_parity) else $error("parity not reported"); // R04
   property p_len;
      ex && !rx_par && rx_csum == 8'h00 && rxb[0] == 8'h50 && rx_cnt != 4'h2
         |=> o_tx_err && o_tx_byte == 8'h0c;
   endproperty
   a_len: assert property (p_len) else $error("length fault missed"); // R05
   property p_nofield;
      ex && pre_code == 8'h00 && rxb[0] == 8'h4a && rxb[1] < 8'(NFIELD)
         && !fused[rxb[1][1:0]] |=> o_tx_err && o_tx_byte == 8'h12;
   endproperty
   a_nofield: assert property (p_nofield) else $error("missing field not refused"); // R10
   property p_guard;
      ex && pre_code == 8'h00 && rxb[0] == 8'h43 && rxb[1] != guard
         |=> o_tx_byte == 8'h0f && $stable(offset);
   endproperty
   a_guard: assert property (p_guard) else $error("guard mismatch accepted"); // R13
   property p_refuse;
      ex && pre_code != 8'h00 && !i_wdt_restart
         |=> latched == $past(pre_code) && $stable(guard) && $stable(fused);
   endproperty
   a_refuse: assert property (p_refuse) else $error("refusal not latched"); // R22
   property p_pos_len;
      ex && pre_code == 8'h00 && rxb[0] == 8'h42 |=> o_tx_valid [*1] ##0 tx_left == 3'd4
         && o_tx_byte[7:3] == 5'h00;
   endproperty
   a_pos_len: assert property (p_pos_len) else $error("position answer malformed"); // R21
   property p_wprot;
      ex && pre_code == 8'h00 && rxb[0] == 8'h4b && rxb[1] < 8'(NFIELD)
         && fused[rxb[1][1:0]] && rxb[2] < {2'b00, fsize[rxb[1][1:0]]}
         && fwp[rxb[1][1:0]] |=> o_tx_byte == 8'h0e;
   endproperty
   a_wprot: assert property (p_wprot) else $error("protected field written"); // R07

   c_setpos: cover property (ex && rxb[0] == 8'h43 && pre_code == 8'h00 && rxb[1] == guard);
   c_store: cover property (ex && rxb[0] == 8'h4b && pre_code == 8'h00);
   c_status: cover property (ex && rxb[0] == 8'h50 && latched != 8'h00);
endmodule

// ---- testbench/ecsu_ctrl_model.sv ----
`timescale 1ns/10ps
// Drive controller: sends one frame, then takes the answer after a chosen stall.
module ecsu_ctrl_model (
   input wire logic i_mclk,
   input wire logic i_rx_ready,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte,
   output logic o_rx_last,
   output logic o_rx_par_err,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_byte,
   input wire logic i_tx_last,
   input wire logic i_tx_err,
   output logic o_tx_ready
);
   initial begin
      o_rx_valid = 1'b0;
      o_rx_byte = 8'h00;
      o_rx_last = 1'b0;
      o_rx_par_err = 1'b0;
      o_tx_ready = 1'b0;
   end
   task automatic run(input logic [7:0] f[$], input int pe, input int stall,
         output logic [7:0] a[$], output logic e);
      int w;
      logic l;
      a = {};
      e = 1'b0;
      l = 1'b0;
      for (int i = 0; i < f.size(); i++) begin
         o_rx_valid = 1'b1;
         o_rx_byte = f[i];
         o_rx_last = (i == f.size() - 1);
         o_rx_par_err = (i == pe);
         w = 0;
         while (i_rx_ready !== 1'b1 && w < 50) begin
            @(posedge i_mclk);
            #1;
            w++;
         end
         @(posedge i_mclk);
         #1;
      end
      // A released line shows the inverse so a stale byte never looks valid.
      o_rx_valid = 1'b0;
      o_rx_byte = ~o_rx_byte;
      o_rx_last = 1'b0;
      o_rx_par_err = 1'b0;
      while (!l) begin
         w = 0;
         while (i_tx_valid !== 1'b1 && w < 50) begin
            @(posedge i_mclk);
            #1;
            w++;
         end
         if (w >= 50) begin
            o_tx_ready = 1'b0;
            break;
         end
         repeat (stall) begin
            @(posedge i_mclk);
            #1;
         end
         o_tx_ready = 1'b1;
         @(posedge i_mclk);
         a.push_back(i_tx_byte);
         e = e | i_tx_err;
         l = i_tx_last;
         #1;
         // Ready stays up between back-to-back bytes, so it never pulses low for zero time.
         if (l || stall > 0) o_tx_ready = 1'b0;
      end
   endtask
endmodule

// ---- testbench/ecsu_top_tb.sv ----
`timescale 1ns/10ps
module ecsu_top_tb;
   // Identity values are arbitrary.
   localparam logic [7:0] TYPE_ID = 8'h3c;
   localparam logic [31:0] SERIAL_NO = 32'h1357_2468;
   localparam logic [7:0] FW_VERSION = 8'h07;
   logic mclk, arst_n, rx_valid, rx_last, rx_par_err, rx_ready;
   logic tx_valid, tx_last, tx_err, tx_ready, wdt, aerr;
   logic [7:0] rx_byte, tx_byte, bus_addr, line_mode, d, a;
   logic [14:0] st_pos;
   logic [11:0] mt_count;
   logic [8:0] flt;
   logic [26:0] t, off;
   logic [31:0] seed;
   logic [7:0] ans[$];
   logic [7:0] fcode[9] = '{8'h01, 8'h02, 8'h03, 8'h1f, 8'h20, 8'h1c, 8'h1d, 8'h1d, 8'h1e};
   int failures, checks;
   ecsu_top #(.TYPE_ID(TYPE_ID), .SERIAL_NO(SERIAL_NO), .FW_VERSION(FW_VERSION)) dut (
      .i_mclk(mclk), .i_arst_n(arst_n), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
      .i_rx_last(rx_last), .i_rx_par_err(rx_par_err), .o_rx_ready(rx_ready),
      .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .o_tx_last(tx_last), .o_tx_err(tx_err),
      .i_tx_ready(tx_ready), .i_st_pos(st_pos), .i_mt_count(mt_count),
      .i_align_bad(flt[0]), .i_offset_bad(flt[1]), .i_table_bad(flt[2]),
      .i_wdt_restart(wdt), .i_speed_high(flt[3]), .i_st_unreliable(flt[4]),
      .i_sig_mon(flt[5]), .i_tx_current(flt[6]), .i_ram_err(flt[7]), .i_temp_crit(flt[8]),
      .o_bus_addr(bus_addr), .o_line_mode(line_mode));
   ecsu_ctrl_model ctl (.i_mclk(mclk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
      .o_rx_byte(rx_byte), .o_rx_last(rx_last), .o_rx_par_err(rx_par_err),
      .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .i_tx_last(tx_last), .i_tx_err(tx_err),
      .o_tx_ready(tx_ready));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] pos(input logic [26:0] o);
      return ({5'h00, mt_count, st_pos} + {5'h00, o}) & 32'h07ff_ffff;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // A pe of -2 corrupts the checksum instead of flagging parity.
   task automatic go(input int n, input logic [63:0] v, input int pe);
      logic [7:0] f[$];
      logic [7:0] c;
      c = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         f.push_back(v[8*i +: 8]);
         c = c ^ v[8*i +: 8];
      end
      f.push_back((pe == -2) ? ~c : c);
      seed = lfsr(seed);
      ctl.run(f, pe, int'(seed[1:0]), ans, aerr);
   endtask
   // An er of 2 leaves the refusal flag unchecked.
   task automatic rsp(input int n, input logic [63:0] v, input int pe, input logic [7:0] e,
         input int er);
      go(n, v, pe);
      chk("answer", {24'h0, e}, {24'h0, ans[0]});
      chk("length", 32'd1, 32'(ans.size()));
      if (er != 2) chk("refusal", er, {31'h0, aerr});
   endtask
   task automatic close_out;
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      close_out;
   end
   initial begin
      arst_n = 1'b0;
      wdt = 1'b0;
      flt = 9'h000;
      st_pos = 15'h0;
      mt_count = 12'h0;
      off = 27'h0;
      seed = 32'hdb775f22;
      failures = 0;
      checks = 0;
      repeat (8) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      rsp(1, 8'h50, -1, 8'h00, 0);
      rsp(3, 24'h55_54_21, -1, 8'h0f, 1);
      chk("bus addr", 32'h0, {24'h0, bus_addr});
      rsp(1, 8'h50, -1, 8'h0f, 0);
      seed = lfsr(seed);
      a = seed[15:8];
      rsp(3, {16'h55_55, a}, -1, 8'h00, 0);
      chk("bus addr", {24'h0, a}, {24'h0, bus_addr});
      rsp(3, {16'h57_56, ~a}, -1, 8'h0f, 1);
      rsp(3, {16'h57_55, ~a}, -1, 8'h00, 0);
      chk("line mode", {24'h0, ~a}, {24'h0, line_mode});
      rsp(1, 8'h50, 0, 8'h09, 1);
      rsp(1, 8'h50, -2, 8'h0a, 1);
      rsp(1, 8'h41, -1, 8'h0b, 1);
      rsp(2, 16'h50_00, -1, 8'h0c, 1);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         st_pos = (k == 0) ? 15'h7fff : seed[14:0];
         mt_count = (k == 0) ? 12'hfff : seed[26:15];
         go(1, 8'h42, -1);
         chk("position", pos(off), {ans[0], ans[1], ans[2], ans[3]});
      end
      t = {12'hfff, seed[30:16]};
      rsp(6, {16'h43_55, 5'h00, t}, -1, 8'h00, 0);
      off = t - {mt_count, st_pos};
      rsp(6, {16'h43_00, 5'h00, ~t}, -1, 8'h0f, 1);
      go(1, 8'h42, -1);
      chk("position", {5'h0, t}, {ans[0], ans[1], ans[2], ans[3]});
      mt_count = mt_count + 12'h001;
      go(1, 8'h42, -1);
      chk("position", pos(off), {ans[0], ans[1], ans[2], ans[3]});
      d = seed[7:0];
      rsp(3, 24'h4a_00_00, -1, 8'h12, 1);
      rsp(4, 32'h4d_00_08_55, -1, 8'h00, 0);
      rsp(4, 32'h4d_01_21_55, -1, 8'h0d, 1);
      rsp(5, {32'h4b_00_03_55, d}, -1, 8'h00, 0);
      rsp(5, {32'h4b_00_1f_55, d}, -1, 8'h11, 1);
      rsp(5, {32'h4b_00_03_54, ~d}, -1, 8'h0f, 1);
      rsp(3, 24'h4a_00_03, -1, d, 0);
      rsp(4, 32'h4d_01_44_55, -1, 8'h00, 0);
      rsp(5, {32'h4b_01_00_55, d}, -1, 8'h0e, 1);
      rsp(4, 32'h4d_02_84_55, -1, 8'h00, 0);
      rsp(4, 32'h4d_02_88_55, -1, 8'h10, 1);
      rsp(1, 8'h52, -1, TYPE_ID, 0);
      rsp(1, 8'h53, -1, 8'h00, 0);
      rsp(1, 8'h50, -1, 8'h00, 0);
      rsp(2, 16'h4c_00, -1, 8'h08, 0);
      rsp(1, 8'h4e, -1, 8'h70, 0);
      rsp(4, 32'h4f_ff_55_5a, -1, 8'h00, 0);
      rsp(3, 24'h55_55_11, -1, 8'h0f, 1);
      rsp(3, 24'h55_5a_11, -1, 8'h00, 0);
      go(1, 8'h56, -1);
      chk("serial", SERIAL_NO, {ans[0], ans[1], ans[2], ans[3]});
      chk("version", {24'h0, FW_VERSION}, {24'h0, ans[4]});
      rsp(1, 8'h50, -1, 8'h0f, 0);
      rsp(1, 8'h50, -1, 8'h00, 0);
      // A mid-run reset must bring back the delivered guard byte and address.
      arst_n = 1'b0;
      @(posedge mclk);
      #1;
      chk("bus addr", 32'h0, {24'h0, bus_addr});
      arst_n = 1'b1;
      rsp(3, 24'h55_55_11, -1, 8'h00, 0);
      chk("bus addr", 32'h11, {24'h0, bus_addr});
      for (int k = 0; k < 9; k++) begin
         flt = 9'h001 << k;
         rsp(1, 8'h50, -1, fcode[k], 0);
      end
      flt = 9'h000;
      @(posedge mclk);
      #1;
      wdt = 1'b1;
      @(posedge mclk);
      #1;
      wdt = 1'b0;
      rsp(1, 8'h50, -1, 8'h07, 0);
      rsp(1, 8'h50, -1, 8'h00, 0);
      close_out;
   end
endmodule
